// ---- logic/sri_pkg.sv ----
package sri_pkg;
  // frame layout
  localparam int          FRAME_BITS     = 8;
  localparam logic [3:0]  FRAME_BITS_C   = 4'h8;
  localparam int          SUM_POS        = 4;
  // register addresses of the serial map
  localparam logic [3:0]  ADDR_MODE      = 4'h0;
  localparam logic [3:0]  ADDR_VOLT      = 4'h1;
  localparam logic [3:0]  ADDR_WAKE      = 4'h2;
  localparam logic [3:0]  ADDR_BUS       = 4'h4;
  localparam logic [3:0]  ADDR_HIGH      = 4'h6;
  localparam logic [3:0]  ADDR_LOW       = 4'h8;
  localparam logic [3:0]  ADDR_TIMING    = 4'ha;
  localparam logic [3:0]  ADDR_MUX       = 4'hc;
  localparam logic [3:0]  ADDR_CONFIG    = 4'hd;
  localparam logic [3:0]  ADDR_IRQ       = 4'he;
  // pair index (address bits 3:1)
  localparam logic [2:0]  PAIR_MODE      = 3'h0;
  localparam logic [2:0]  PAIR_MUX       = 3'h6;
  // mode control fields
  localparam int          MODE_OVS_POS   = 3;
  localparam int          MODE_PULL_POS  = 2;
  localparam int          MODE_HI_POS    = 1;
  localparam int          MODE_LO_POS    = 0;
  localparam logic [1:0]  MODE_WD_CLEAR  = 2'h3;
  // reset values
  localparam logic [3:0]  MODE_RESET     = 4'hc;
  localparam logic [3:0]  WAKE_RESET     = 4'hf;
  localparam logic [3:0]  CTRL_RESET     = 4'h0;
  localparam logic [1:0]  MODE_SEL_RESET = 2'h0;
  // host command port
  localparam logic [1:0]  HOST_TX        = 2'h0;
  localparam logic [1:0]  HOST_STAT      = 2'h1;
  localparam logic [1:0]  HOST_RX        = 2'h2;
  localparam int          HOST_BUSY_POS  = 0;
  localparam int          HOST_DONE_POS  = 1;
  // timing
  localparam int          CLK_NS         = 25;
  localparam int          SCLK_HALF_NS   = 500;
  localparam logic [7:0]  SCLK_HALF_CYC  =
    8'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS);

  function automatic logic [3:0] ctrl_reset_val(input logic [2:0] pair);
    if (pair == PAIR_MODE)
      return MODE_RESET;
    else if (pair == 3'h1)
      return WAKE_RESET;
    else
      return CTRL_RESET;
  endfunction
endpackage

// ---- logic/sri_link_if.sv ----
`timescale 1ns/1ps
interface sri_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic miso_line;

  // released line floats high via pull
  assign miso_line = miso_oe_n ? 1'b1 : miso;

  modport dev  (input cs_n, input sclk, input mosi,
                output miso, output miso_oe_n);
  modport host (output cs_n, output sclk, output mosi,
                input miso_line);
endinterface

// ---- logic/sri_sync.sv ----
`timescale 1ns/1ps
module sri_sync #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // pin in, filtered level out
  input  wire logic d,
  output logic      q
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;

  // level changes only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      q_r  <= INIT;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= (s2_r == s3_r) ? s2_r : q_r;
    end
  end

  assign q = q_r;
endmodule

// ---- logic/sri_device.sv ----
// Notes on behaviour
// - one byte each way per select
// - master sends address then control nibble
// - reply summary nibble then register status
// - select fall starts, drives, snapshots status
// - shift on rising, sample on falling
// - valid only with eight sampling edges
// - select rise commits control nibble
// - output released while select high
// - bits reset per their reset causes
// - even writes, odd reads except config 0xd, pair shares status
// - summary nibble sits in bits 7:4
// - summary bits OR voltage, bus, high-side, low-side status
// - mode write returns voltage status
// - bit 3 overvoltage shutdown, reset one
// - bit 2 bus pull-up and wake threshold
// - mode bits decode normal/stop/sleep/clear
// - voltage nibble ov, uv, overtemp, battery_fail_flag
// - battery fail set at power-on, access clears
// - each control write returns its status, mux pair returns zero
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module sri_device
  import sri_pkg::*;
(
  // clock and power-on reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // further reset causes
  input  wire logic       reset_mode,
  input  wire logic       ext_reset,
  // serial link
  sri_link_if.dev         link,
  // live status
  input  wire logic       supply_overvoltage,
  input  wire logic       supply_undervoltage,
  input  wire logic       regulator_overtemp_warning,
  input  wire logic [3:0] wake_input_status,
  input  wire logic [3:0] bus_transceiver_status,
  input  wire logic [3:0] high_side_status,
  input  wire logic [3:0] low_side_status,
  input  wire logic [3:0] watchdog_status,
  input  wire logic [3:0] interrupt_source,
  // mode control
  output logic            overvoltage_shutdown_enable,
  output logic            bus_pullup_enable,
  output logic            mode_select_high,
  output logic            mode_select_low,
  output logic            watchdog_clear,
  output logic            battery_fail_flag,
  // other control registers
  output logic [3:0]      wake_input_control,
  output logic [3:0]      bus_transceiver_control,
  output logic [3:0]      high_side_control,
  output logic [3:0]      low_side_control,
  output logic [3:0]      timing_control,
  output logic [3:0]      analog_mux_control,
  output logic [3:0]      configuration,
  output logic [3:0]      interrupt_mask
);
  ////////////////////////////////////////////////////////////////////////////
  logic       cs_q;
  logic       sclk_q;
  logic       mosi_q;
  logic       cs_d_r;
  logic       sclk_d_r;
  logic       active_r;
  logic [3:0] fall_cnt_r;
  logic [3:0] rise_cnt_r;
  logic [7:0] rx_r;
  logic [3:0] addr_r;
  logic [3:0] sum_r;
  logic [3:0] snap_r [0:7];
  logic [3:0] ctrl_r [0:7];
  logic [3:0] cfg_r;
  logic       bat_r;
  logic       wd_clr_r;
  logic       miso_r;
  logic       oe_n_r;

  sri_sync #(.INIT(1'b1)) u_cs (
    .clk    (clk),
    .resetn (resetn),
    .d      (link.cs_n),
    .q      (cs_q)
  );
  sri_sync #(.INIT(1'b0)) u_sclk (
    .clk    (clk),
    .resetn (resetn),
    .d      (link.sclk),
    .q      (sclk_q)
  );
  sri_sync #(.INIT(1'b0)) u_mosi (
    .clk    (clk),
    .resetn (resetn),
    .d      (link.mosi),
    .q      (mosi_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // edges and decode
  wire        cs_fall    = cs_d_r & ~cs_q;
  wire        cs_rise    = ~cs_d_r & cs_q;
  wire        sclk_rise  = ~cs_q & ~sclk_d_r & sclk_q;
  wire        sclk_fall  = ~cs_q & sclk_d_r & ~sclk_q;
  wire [3:0]  volt_live  = {supply_overvoltage, supply_undervoltage,
                            regulator_overtemp_warning, bat_r};
  // summary is OR of four registers
  wire [3:0]  sum_live   = {|volt_live, |bus_transceiver_status,
                            |high_side_status, |low_side_status};
  wire [2:0]  pair       = addr_r[3:1];
  wire [7:0]  tx_word    = {sum_r, snap_r[pair]};
  wire [2:0]  tx_idx     = 3'(7 - int'(rise_cnt_r));
  wire        frame_ok   = active_r & cs_rise & (fall_cnt_r == FRAME_BITS_C);
  // even writes; odd config slot writes too
  wire        is_write   = ~addr_r[0] | (addr_r == ADDR_CONFIG);
  wire        other_rst  = reset_mode | ext_reset;
  wire [3:0]  ctrl_in    = rx_r[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // frame tracking
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cs_d_r     <= 1'b1;
      sclk_d_r   <= 1'b0;
      active_r   <= 1'b0;
      fall_cnt_r <= 4'h0;
      rise_cnt_r <= 4'h0;
      rx_r       <= 8'h00;
      addr_r     <= 4'h0;
    end else begin
      cs_d_r   <= cs_q;
      sclk_d_r <= sclk_q;
      if (cs_fall) begin
        active_r   <= 1'b1;
        fall_cnt_r <= 4'h0;
        rise_cnt_r <= 4'h0;
      end else if (cs_rise) begin
        active_r <= 1'b0;
      end
      if (sclk_fall && active_r) begin
        // sample on falling edge, msb first
        rx_r <= {rx_r[6:0], mosi_q};
        if (fall_cnt_r != 4'hf)
          fall_cnt_r <= fall_cnt_r + 4'h1;
        if (fall_cnt_r == 4'h3)
          addr_r <= {rx_r[2:0], mosi_q};
      end
      if (sclk_rise && active_r && rise_cnt_r != 4'hf)
        rise_cnt_r <= rise_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sum_r <= 4'h0;
      for (int i = 0; i < 8; i++)
        snap_r[i] <= 4'h0;
    end else if (cs_fall) begin
      sum_r     <= sum_live;
      snap_r[0] <= volt_live;
      // each pair returns its own status, except the mux pair, which returns zero
      snap_r[1] <= wake_input_status;
      snap_r[2] <= bus_transceiver_status;
      snap_r[3] <= high_side_status;
      snap_r[4] <= low_side_status;
      snap_r[5] <= watchdog_status;
      snap_r[6] <= 4'h0;
      snap_r[7] <= interrupt_source;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output
  always_ff @(posedge clk) begin
    if (!resetn) begin
      miso_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= cs_q;
      if (cs_fall)
        miso_r <= sum_live[3];
      else if (sclk_rise && active_r)
        miso_r <= (rise_cnt_r < FRAME_BITS_C) ? tx_word[tx_idx] : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      // shutdown and pull-up reset to one
      for (int i = 0; i < 8; i++)
        ctrl_r[i] <= ctrl_reset_val(3'(i));
      cfg_r    <= CTRL_RESET;
      wd_clr_r <= 1'b0;
    end else if (other_rst) begin
      // mode bits 3:2 keep, only power-on resets them
      ctrl_r[0] <= {ctrl_r[0][3:2], MODE_SEL_RESET};
      for (int i = 1; i < 8; i++)
        ctrl_r[i] <= ctrl_reset_val(3'(i));
      cfg_r    <= CTRL_RESET;
      wd_clr_r <= 1'b0;
    end else begin
      wd_clr_r <= 1'b0;
      if (frame_ok && is_write) begin
        if (addr_r == ADDR_CONFIG)
          cfg_r <= ctrl_in;
        else
          ctrl_r[pair] <= ctrl_in;
        // both mode bits set clears watchdog
        if (pair == PAIR_MODE && ctrl_in[1:0] == MODE_WD_CLEAR)
          wd_clr_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn)
      bat_r <= 1'b1;
    // any mode or voltage access clears
    else if (frame_ok && pair == PAIR_MODE)
      bat_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.miso                   = miso_r;
  assign link.miso_oe_n              = oe_n_r;
  assign overvoltage_shutdown_enable = ctrl_r[0][MODE_OVS_POS];
  assign bus_pullup_enable           = ctrl_r[0][MODE_PULL_POS];
  assign mode_select_high            = ctrl_r[0][MODE_HI_POS];
  assign mode_select_low             = ctrl_r[0][MODE_LO_POS];
  assign watchdog_clear              = wd_clr_r;
  assign battery_fail_flag           = bat_r;
  assign wake_input_control          = ctrl_r[1];
  assign bus_transceiver_control     = ctrl_r[2];
  assign high_side_control           = ctrl_r[3];
  assign low_side_control            = ctrl_r[4];
  assign timing_control              = ctrl_r[5];
  assign analog_mux_control          = ctrl_r[PAIR_MUX];
  assign configuration               = cfg_r;
  assign interrupt_mask              = ctrl_r[7];
endmodule

// ---- logic/sri_host.sv ----
`timescale 1ns/1ps
module sri_host
  import sri_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // command port
  input  wire logic [1:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic       cmd_wr,
  input  wire logic       cmd_rd,
  output logic [7:0]      cmd_rdata,
  // serial link
  sri_link_if.host        link
);
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_LEAD  = 3'b001,
    H_HIGH  = 3'b010,
    H_LOW   = 3'b011,
    H_TRAIL = 3'b100,
    H_GAP   = 3'b101
  } sri_hstate_t;

  sri_hstate_t state_r;
  sri_hstate_t state_nxt;
  logic [7:0]  cnt_r;
  logic [3:0]  bits_r;
  logic [7:0]  tx_r;
  logic [7:0]  rx_r;
  logic        done_r;
  logic        cs_n_r;
  logic        sclk_r;
  logic        mosi_r;
  logic [7:0]  rdata_r;
  logic        miso_q;

  sri_sync #(.INIT(1'b1)) u_miso (
    .clk    (clk),
    .resetn (resetn),
    .d      (link.miso_line),
    .q      (miso_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  wire half_done = (cnt_r == SCLK_HALF_CYC - 8'h1);
  wire busy      = (state_r != H_IDLE);
  // starts ignored while a frame runs
  wire start     = cmd_wr & (cmd_addr == HOST_TX) & ~busy;
  wire last_bit  = (bits_r == FRAME_BITS_C);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      H_IDLE:  state_nxt = start ? H_LEAD : H_IDLE;
      H_LEAD:  state_nxt = half_done ? H_HIGH : H_LEAD;
      H_HIGH:  state_nxt = half_done ? H_LOW : H_HIGH;
      H_LOW:   state_nxt = !half_done ? H_LOW : (last_bit ? H_TRAIL : H_HIGH);
      H_TRAIL: state_nxt = half_done ? H_GAP : H_TRAIL;
      H_GAP:   state_nxt = half_done ? H_IDLE : H_GAP;
      default: state_nxt = H_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= H_IDLE;
      cnt_r   <= 8'h00;
      bits_r  <= 4'h0;
      tx_r    <= 8'h00;
      rx_r    <= 8'h00;
      done_r  <= 1'b0;
      cs_n_r  <= 1'b1;
      sclk_r  <= 1'b0;
      mosi_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt != state_r || half_done) ? 8'h00 : cnt_r + 8'h1;
      if (start) begin
        tx_r   <= cmd_wdata;
        bits_r <= 4'h0;
        done_r <= 1'b0;
        cs_n_r <= 1'b0;
      end
      if (state_r != H_HIGH && state_nxt == H_HIGH) begin
        sclk_r <= 1'b1;
        mosi_r <= tx_r[7];
        tx_r   <= {tx_r[6:0], 1'b0};
      end
      if (state_r == H_HIGH && state_nxt == H_LOW) begin
        sclk_r <= 1'b0;
        rx_r   <= {rx_r[6:0], miso_q};
        bits_r <= bits_r + 4'h1;
      end
      if (state_r == H_TRAIL && state_nxt == H_GAP) begin
        cs_n_r <= 1'b1;
        done_r <= 1'b1;
      end
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!resetn)
      rdata_r <= 8'h00;
    else if (cmd_rd)
      case (cmd_addr)
        HOST_STAT: rdata_r <= {6'h00, done_r, busy};
        HOST_RX:   rdata_r <= rx_r;
        default:   rdata_r <= 8'h00;
      endcase
    else
      rdata_r <= 8'h00;
  end

  assign cmd_rdata = rdata_r;
  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign link.mosi = mosi_r;
endmodule

// ---- dv/sri_monitor.sv ----
`timescale 1ns/1ps
module sri_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link lines
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic miso_line
);
  logic       sclk_q_r;
  logic [3:0] falls_r;

  // sampling edges of the open frame
  always_ff @(posedge clk) begin
    sclk_q_r <= sclk;
    if (!resetn || cs_n) begin
      falls_r <= 4'h0;
    end else if (sclk_q_r && !sclk) begin
      falls_r <= falls_r + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
////////////////////////////////////////////////////////////
  // margin of 8 covers the device's input synchroniser lag
  sequence s_rise_settled;
    $rose(sclk) ##8 1;
  endsequence
  sequence s_cs_idle;
    cs_n [*8];
  endsequence

  property p_oe_on;
    $fell(cs_n) |-> ##[1:6] !miso_oe_n;
  endproperty
  property p_oe_off;
    $rose(cs_n) |-> ##[1:6] miso_oe_n;
  endproperty
  property p_idle_release;
    s_cs_idle |-> miso_oe_n && miso_line;
  endproperty
  property p_sclk_idle;
    cs_n |-> !sclk;
  endproperty
  property p_cs_gap;
    $rose(cs_n) |=> cs_n [*8];
  endproperty
  property p_mosi_hold;
    $rose(sclk) |=> $stable(mosi) [*8];
  endproperty
  property p_miso_hold;
    s_rise_settled |-> $stable(miso) [*8];
  endproperty
  property p_eight;
    $rose(cs_n) |-> falls_r == 4'h8;
  endproperty
////////////////////////////////////////////////////////////
  a_oe_on: assert property (p_oe_on)
    else $error("output not driven after select fall");
  a_oe_off: assert property (p_oe_off)
    else $error("output not released after select rise");
  a_idle_release: assert property (p_idle_release)
    else $error("output driven while deselected");
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock high outside frame");
  a_cs_gap: assert property (p_cs_gap)
    else $error("frames too close");
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("host data moved while clock high");
  a_miso_hold: assert property (p_miso_hold)
    else $error("device data moved before sampling edge");
  a_eight: assert property (p_eight)
    else $error("frame without eight sampling edges");
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  err_count++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module tb_top
  import sri_pkg::*;
;
  logic       clk, resetn, reset_mode, ext_reset;
  logic       vs_ov, vs_uv, vs_ot, bf, wdc_seen, sq;
  logic       cmd_wr, cmd_rd;
  logic [1:0] cmd_addr;
  logic [7:0] cmd_wdata, mo, mi;
  logic [3:0] st [0:7];
  logic [3:0] ectl [0:7];
  logic [3:0] ecfg;
  wire  [7:0] cmd_rdata;
  wire  [3:0] ctl [0:7];
  wire  [3:0] cfg, mode2;
  wire        bfail, wdc, bf2;
  int         err_count, samples_checked;

  sri_link_if link_a ();
  sri_link_if link_b ();
  sri_host sri_host_i (.clk(clk), .resetn(resetn), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_rdata(cmd_rdata), .link(link_a));
  sri_device sri_device_i (.clk(clk), .resetn(resetn),
    .reset_mode(reset_mode), .ext_reset(ext_reset), .link(link_a),
    .supply_overvoltage(vs_ov), .supply_undervoltage(vs_uv),
    .regulator_overtemp_warning(vs_ot), .wake_input_status(st[1]),
    .bus_transceiver_status(st[2]), .high_side_status(st[3]),
    .low_side_status(st[4]), .watchdog_status(st[5]),
    .interrupt_source(st[7]), .overvoltage_shutdown_enable(ctl[0][3]),
    .bus_pullup_enable(ctl[0][2]), .mode_select_high(ctl[0][1]),
    .mode_select_low(ctl[0][0]), .watchdog_clear(wdc),
    .battery_fail_flag(bfail), .wake_input_control(ctl[1]),
    .bus_transceiver_control(ctl[2]), .high_side_control(ctl[3]),
    .low_side_control(ctl[4]), .timing_control(ctl[5]),
    .analog_mux_control(ctl[6]), .configuration(cfg),
    .interrupt_mask(ctl[7]));
  // second device faces a bench driver that miscounts edges
  sri_device sri_device_i2 (.clk(clk), .resetn(resetn),
    .reset_mode(reset_mode), .ext_reset(ext_reset), .link(link_b),
    .supply_overvoltage(vs_ov), .supply_undervoltage(vs_uv),
    .regulator_overtemp_warning(vs_ot), .wake_input_status(st[1]),
    .bus_transceiver_status(st[2]), .high_side_status(st[3]),
    .low_side_status(st[4]), .watchdog_status(st[5]),
    .interrupt_source(st[7]), .overvoltage_shutdown_enable(mode2[3]),
    .bus_pullup_enable(mode2[2]), .mode_select_high(mode2[1]),
    .mode_select_low(mode2[0]), .watchdog_clear(),
    .battery_fail_flag(bf2), .wake_input_control(),
    .bus_transceiver_control(), .high_side_control(),
    .low_side_control(), .timing_control(), .analog_mux_control(),
    .configuration(), .interrupt_mask());
  sri_monitor sri_monitor_i (.clk(clk), .resetn(resetn),
    .cs_n(link_a.cs_n), .sclk(link_a.sclk), .mosi(link_a.mosi),
    .miso(link_a.miso), .miso_oe_n(link_a.miso_oe_n),
    .miso_line(link_a.miso_line));

  always #12.5 clk = ~clk;

  // wire-level capture at each sampling edge
  always @(posedge clk) begin
    sq <= link_a.sclk;
    if (!link_a.cs_n && sq && !link_a.sclk) begin
      mo <= {mo[6:0], link_a.mosi};
      mi <= {mi[6:0], link_a.miso_line};
    end
    if (wdc === 1'b1) wdc_seen <= 1'b1;
  end
////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_rx(input logic [3:0] a);
    logic [3:0] v;
    logic [3:0] lo;
    v = {vs_ov, vs_uv, vs_ot, bf};
    lo = (a[3:1] == 3'h0) ? v : (a[3:1] == 3'h6) ? 4'h0 : st[a[3:1]];
    return {|v, |st[2], |st[3], |st[4], lo};
  endfunction

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    cmd_rd <= 1'b1;
    cmd_addr <= a;
    @(posedge clk);
    cmd_rd <= 1'b0;
    #1 d = cmd_rdata;
  endtask

  // poll waits out the host's own gap too, so frames never collide
  task automatic frame(input logic [3:0] a, input logic [3:0] c);
    logic [7:0] s;
    logic [7:0] rx;
    logic [7:0] ex;
    ex = exp_rx(a);
    s = 8'h00;
    wr(HOST_TX, {a, c});
    for (int i = 0; i < 500 && s[1:0] !== 2'h2; i++)
      rd(HOST_STAT, s);
    // poll limit running out counts as a mismatch
    `CHK(s[1:0], 2'h2)
    rd(HOST_RX, rx);
    `CHK(rx, ex)
    `CHK(mo, {a, c})
    `CHK(mi, ex)
    if (a[3:1] == 3'h0) bf = 1'b0;
  endtask

  task automatic raw(input logic [7:0] b, input int n);
    @(posedge clk);
    link_b.cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      link_b.sclk <= 1'b1;
      link_b.mosi <= b[3'(7 - i)];
      repeat (4) @(posedge clk);
      link_b.sclk <= 1'b0;
      repeat (4) @(posedge clk);
    end
    link_b.cs_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask

  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    reset_mode = 1'b0;
    ext_reset = 1'b0;
    cmd_addr = 2'h0;
    cmd_wdata = 8'h00;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    link_b.cs_n = 1'b1;
    link_b.sclk = 1'b0;
    link_b.mosi = 1'b0;
    vs_ov = 1'b1;
    vs_uv = 1'b0;
    vs_ot = 1'b1;
    bf = 1'b1;
    wdc_seen = 1'b0;
    st = '{4'h0, 4'h2, 4'h0, 4'h1, 4'h8, 4'h5, 4'h0, 4'ha};
    ectl = '{4'hc, 4'hf, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
    ecfg = 4'h0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    for (int p = 0; p < 8; p++) `CHK(ctl[p], ectl[p])
    `CHK(bfail, 1'b1)
    // odd address reads voltage status and must not write
    frame(4'h1, 4'h5);
    `CHK(ctl[0], 4'hc)
    `CHK(bfail, 1'b0)
    for (int m = 0; m < 4; m++) begin
      wdc_seen = 1'b0;
      ectl[0] = {2'(3 - m), 2'(m)};
      frame(4'h0, ectl[0]);
      `CHK(ctl[0], ectl[0])
      `CHK(wdc_seen, 1'(m == 3))
    end
    for (int a = 2; a < 16; a++) begin
      frame(4'(a), 4'(a) ^ 4'h5);
      if (a == 13)
        ecfg = 4'(a) ^ 4'h5;
      else if (a % 2 == 0)
        ectl[a / 2] = 4'(a) ^ 4'h5;
      `CHK(ctl[a / 2], ectl[a / 2])
      `CHK(cfg, ecfg)
    end
    // status moving mid-frame must not reach the reply
    fork
      frame(4'h6, 4'h3);
      begin
        repeat (60) @(posedge clk);
        st[3] <= 4'h0;
      end
    join
    for (int k = 0; k < 2; k++) begin
      frame(4'h4, 4'h9);
      @(posedge clk);
      reset_mode <= (k == 0);
      ext_reset <= (k == 1);
      @(posedge clk);
      reset_mode <= 1'b0;
      ext_reset <= 1'b0;
      repeat (2) @(posedge clk);
      ectl[0][1:0] = 2'h0;
      for (int p = 1; p < 8; p++) ectl[p] = (p == 1) ? 4'hf : 4'h0;
      ecfg = 4'h0;
      for (int p = 0; p < 8; p++) `CHK(ctl[p], ectl[p])
      `CHK(cfg, ecfg)
      `CHK(bfail, bf)
    end
    // shifted nine-edge frame would commit a different nibble
    for (int n = 7; n < 10; n++) begin
      raw(8'h0b, n);
      `CHK(mode2, (n == 7) ? 4'hc : 4'hb)
      `CHK(bf2, 1'(n == 7))
    end
    print_verdict();
  end
endmodule
